// ### cell_balancing_sequencer.sv
/*
  cell balancing sequencer: global enable, timeout, prebalance delay,
  thermal and measurement pauses, emergency discharge, channel completion
  and switch diagnostics, with an apb register slave.
  assumes synchronous inputs, a one-cycle 10 s tick from the slow timebase,
  and measurement / comparator blocks outside that deliver the flags.
*/
`timescale 1ns/100ps
//
// Contract
// RULE_01 - thermal protection always on while enabled
// RULE_02 - hot die pauses all cells, holds timers
// RULE_03 - resume once cooled by hysteresis
// RULE_04 - thermal pause leaves global timeout running
// RULE_05 - measurement pause inhibits, timeout still runs
// RULE_06 - enable key starts full-duty discharge
// RULE_07 - disable key or supply low stops
// RULE_08 - discharge runs without global enable
// RULE_09 - discharge holds timeout, never ended by it
// RULE_10 - battery overvoltage holds discharge, releases timeout
// RULE_11 - switch error turns that channel off
// RULE_12 - everything else needs global enable; the global timeout counts down and expires without it
// RULE_13 - completed channel clears its enable bit
// RULE_14 - decisions use latched cyclic measurement
// RULE_15 - no channels left: clear enable, set ready
// RULE_16 - timeout, timers, undervoltage clear channel bits
// RULE_17 - no record of clearing cause
// RULE_18 - two status words of switch states
// RULE_19 - two status words of switch faults
// RULE_20 - per-switch monitoring with own enable
// RULE_21 - timeout counts per tick, expiry stops all but emergency discharge
// RULE_22 - discharge control resets to disable key
module cell_balancing_sequencer
  import bal_pkg::*;
(
  input wire logic pclk, // apb clock, 20 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic tick_10s, // one-cycle pulse every 10 s
  input wire logic [15:0] jt_temp, // primary junction temperature
  input wire logic [15:0] jt_upper, // thermal upper threshold
  input wire logic [15:0] jt_hyst, // thermal hysteresis
  input wire logic meas_pause, // pause request from measurement
  input wire logic meas_done, // pulse: cyclic measurement result valid
  input wire logic [NCH-1:0] cell_uv, // cell below own uv threshold
  input wire logic [NCH-1:0] glob_uv, // cell below global uv threshold
  input wire logic [NCH-1:0] tmr_expired, // per-channel timer expired
  input wire logic supply_low, // supply low-voltage condition
  input wire logic vbat_ov, // battery supply overvoltage flag
  input wire logic [NCH-1:0] sw_closed, // sensed switch closed
  input wire logic [NCH-1:0] sw_ovc, // switch overcurrent
  input wire logic [NCH-1:0] sw_open_load, // switch open load
  output logic [NCH-1:0] sw_on, // balancing switch drive
  output logic timers_hold // hold per-channel timers
);

  bal_st_t st_ff; // all state
  bal_st_t nxt_st; // next state
  logic [NCH-1:0] sw_err; // per-switch fault this cycle

  // index match for a byte address
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    hit = (a[15:2] == idx[13:0]) && (a[1:0] == 2'h0);
  endfunction

  // per-switch monitor, each gated by its own enable; deviation of the
  // sensed state from the commanded one, overcurrent or open load
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_mon
      assign sw_err[g] = st_ff.mon_en[g] &&
        (st_ff.cfg[CFG_EN] || st_ff.ed != ED_OFF) && // see RULE_12
        ((sw_closed[g] != st_ff.sw_on[g]) || sw_ovc[g] ||
         sw_open_load[g]); // see RULE_19 see RULE_20
    end
  endgenerate

  // next-state logic
  always_comb begin
    logic wr; // write completes this cycle
    logic rd; // read completes this cycle
    logic en; // global enable after software write
    logic active; // normal balancing may drive switches
    logic ed_on; // discharge drives switches
    logic to_exp; // global timeout reaches zero now
    logic clr_all; // all channel bits cleared at once
    logic [NCH-1:0] done; // channels completed this cycle
    logic [16:0] cool; // temperature plus hysteresis
    logic mapped; // address belongs to the map
    nxt_st = st_ff;
    wr = psel && penable && pwrite && !st_ff.pready;
    rd = psel && penable && !pwrite && !st_ff.pready;
    cool = {1'b0, jt_temp} + {1'b0, jt_hyst};
    to_exp = 1'b0;
    clr_all = 1'b0;
    done = '0;
    // defaults, so no path leaves a local undriven
    en = 1'b0;
    active = 1'b0;
    ed_on = 1'b0;
    mapped = hit(paddr, IDX_GLOB_CFG) || hit(paddr, IDX_TIMEOUT) ||
      hit(paddr, IDX_CHEN_LO) || hit(paddr, IDX_CHEN_HI) ||
      hit(paddr, IDX_PREBAL) || hit(paddr, IDX_ED_CTRL) ||
      hit(paddr, IDX_MON_LO) || hit(paddr, IDX_MON_HI) ||
      hit(paddr, IDX_STATUS) || hit(paddr, IDX_SW_LO) ||
      hit(paddr, IDX_SW_HI) || hit(paddr, IDX_FLT_LO) ||
      hit(paddr, IDX_FLT_HI);

    // apb: one wait cycle, answer registered
    nxt_st.pready = psel && penable && !st_ff.pready;
    nxt_st.pslverr = psel && penable && !st_ff.pready && !mapped;
    if (rd) begin
      nxt_st.prdata = 32'h0000_0000;
      if (hit(paddr, IDX_GLOB_CFG)) begin
        nxt_st.prdata[15:0] = st_ff.cfg;
      end
      if (hit(paddr, IDX_TIMEOUT)) begin
        nxt_st.prdata[15:0] = st_ff.timeout;
      end
      if (hit(paddr, IDX_CHEN_LO)) begin
        nxt_st.prdata[15:0] = st_ff.chen[15:0];
      end
      if (hit(paddr, IDX_CHEN_HI)) begin
        nxt_st.prdata[1:0] = st_ff.chen[17:16];
      end
      if (hit(paddr, IDX_PREBAL)) begin
        nxt_st.prdata[15:0] = st_ff.prebal;
      end
      if (hit(paddr, IDX_ED_CTRL)) begin
        nxt_st.prdata[15:0] = st_ff.ed_ctrl;
      end
      if (hit(paddr, IDX_MON_LO)) begin
        nxt_st.prdata[15:0] = st_ff.mon_en[15:0];
      end
      if (hit(paddr, IDX_MON_HI)) begin
        nxt_st.prdata[1:0] = st_ff.mon_en[17:16];
      end
      if (hit(paddr, IDX_STATUS)) begin // cause of clearing not kept, see RULE_17
        nxt_st.prdata[ST_RDY] = st_ff.rdy;
        nxt_st.prdata[ST_THERM] = st_ff.therm;
        nxt_st.prdata[ST_ED] = (st_ff.ed == ED_RUN);
      end
      // physical state as sensed, so a stuck switch shows here
      if (hit(paddr, IDX_SW_LO)) begin // see RULE_18
        nxt_st.prdata[15:0] = sw_closed[15:0];
      end
      if (hit(paddr, IDX_SW_HI)) begin // see RULE_18
        nxt_st.prdata[1:0] = sw_closed[17:16];
      end
      if (hit(paddr, IDX_FLT_LO)) begin // see RULE_19
        nxt_st.prdata[15:0] = st_ff.fault[15:0];
      end
      if (hit(paddr, IDX_FLT_HI)) begin // see RULE_19
        nxt_st.prdata[1:0] = st_ff.fault[17:16];
      end
    end

    // software writes; hardware updates below take precedence
    if (wr) begin
      if (hit(paddr, IDX_GLOB_CFG)) begin
        nxt_st.cfg = pwdata[15:0];
        if (pwdata[CFG_EN]) begin
          nxt_st.rdy = 1'b0; // new run, not ready yet
        end
      end
      if (hit(paddr, IDX_TIMEOUT)) begin
        nxt_st.timeout = pwdata[15:0];
      end
      if (hit(paddr, IDX_CHEN_LO)) begin
        nxt_st.chen[15:0] = pwdata[15:0];
      end
      if (hit(paddr, IDX_CHEN_HI)) begin
        nxt_st.chen[17:16] = pwdata[1:0];
      end
      if (hit(paddr, IDX_PREBAL)) begin
        nxt_st.prebal = pwdata[15:0];
      end
      if (hit(paddr, IDX_ED_CTRL)) begin
        nxt_st.ed_ctrl = pwdata[15:0];
        if (pwdata[15:0] == ED_KEY_ON) begin // see RULE_06
          nxt_st.ed = vbat_ov ? ED_HOLD : ED_RUN;
        end else if (pwdata[15:0] == ED_KEY_OFF) begin // see RULE_07
          nxt_st.ed = ED_OFF;
        end
      end
      if (hit(paddr, IDX_MON_LO)) begin
        nxt_st.mon_en[15:0] = pwdata[15:0];
      end
      if (hit(paddr, IDX_MON_HI)) begin
        nxt_st.mon_en[17:16] = pwdata[1:0];
      end
      // faults clear by writing one; a new fault still wins below
      if (hit(paddr, IDX_FLT_LO)) begin
        nxt_st.fault[15:0] = st_ff.fault[15:0] & ~pwdata[15:0];
      end
      if (hit(paddr, IDX_FLT_HI)) begin
        nxt_st.fault[17:16] = st_ff.fault[17:16] & ~pwdata[1:0];
      end
    end

    // emergency discharge sequencing, independent of global enable
    case (st_ff.ed)
      ED_OFF: begin
        nxt_st.ed = nxt_st.ed; // only a key write leaves this state
      end
      ED_RUN: begin
        if (vbat_ov && nxt_st.ed == ED_RUN) begin
          nxt_st.ed = ED_HOLD; // see RULE_10
        end
      end
      ED_HOLD: begin
        if (!vbat_ov && nxt_st.ed == ED_HOLD) begin
          nxt_st.ed = ED_RUN; // flag cleared by software, see RULE_10
        end
      end
      default: begin
        nxt_st.ed = ED_OFF;
      end
    endcase
    // supply low beats every key write and every hold
    if (supply_low) begin // see RULE_07
      nxt_st.ed = ED_OFF;
      nxt_st.ed_ctrl = ED_KEY_OFF;
    end

    // cyclic measurement result latched once per measurement
    if (meas_done) begin // see RULE_14
      nxt_st.uv_cell = cell_uv;
      nxt_st.uv_glob = glob_uv;
    end

    // die temperature protection with hysteresis, cannot be disabled
    if (jt_temp > jt_upper) begin // see RULE_01 see RULE_02
      nxt_st.therm = 1'b1;
    end else if (cool <= {1'b0, jt_upper}) begin // see RULE_03
      nxt_st.therm = 1'b0;
    end

    en = nxt_st.cfg[CFG_EN];

    // global timeout: runs through pauses, held while discharge drives
    // a discharge on overvoltage hold lets it count, so it may expire there
    if (tick_10s && st_ff.timeout != 16'h0000 &&
        st_ff.ed != ED_RUN) begin // see RULE_04 see RULE_05 see RULE_09
      nxt_st.timeout = st_ff.timeout - 16'h0001; // see RULE_21
      to_exp = (st_ff.timeout == 16'h0001);
    end

    // prebalance delay counts only while enabled
    if (tick_10s && st_ff.cfg[CFG_EN] && st_ff.prebal != 16'h0000) begin
      nxt_st.prebal = st_ff.prebal - 16'h0001;
    end

    // completion decisions only while balancing is enabled; timeout expiry below clears channels regardless
    // hardware clears override a software write in the same cycle
    if (en && st_ff.cfg[CFG_EN]) begin // see RULE_12
      if (nxt_st.cfg[CFG_TMR]) begin // see RULE_13
        done = done | (tmr_expired & st_ff.chen);
        if (&(tmr_expired | ~st_ff.chen)) begin // see RULE_16
          clr_all = 1'b1;
        end
      end
      if (nxt_st.cfg[CFG_CELLUV]) begin // see RULE_13
        done = done | (st_ff.uv_cell & st_ff.chen);
        if (&(st_ff.uv_cell | ~st_ff.chen)) begin // see RULE_16
          clr_all = 1'b1;
        end
      end
      if (nxt_st.cfg[CFG_GLOBUV] && |(st_ff.uv_glob & st_ff.chen)) begin
        clr_all = 1'b1; // see RULE_16
      end
      done = done | sw_err; // see RULE_11
    end
    if (to_exp) begin // see RULE_16 see RULE_21
      clr_all = 1'b1;
      nxt_st.cfg[CFG_EN] = 1'b0;
    end
    nxt_st.chen = clr_all ? '0 : (nxt_st.chen & ~done);

    // run finished once no channel remains enabled
    if (st_ff.cfg[CFG_EN] && en && nxt_st.chen == '0) begin // see RULE_15
      nxt_st.cfg[CFG_EN] = 1'b0;
      nxt_st.rdy = 1'b1;
    end

    // fault capture, set wins over a software clear
    // limitation: a sense path lagging the drive by a cycle reads as a
    // deviation here, so the switch sense must settle within one clock
    nxt_st.fault = nxt_st.fault | sw_err; // see RULE_19

    // switch drive: discharge at full duty overrides normal balancing
    active = st_ff.cfg[CFG_EN] && st_ff.prebal == 16'h0000 &&
      !st_ff.therm && !meas_pause; // see RULE_02 see RULE_05
    ed_on = (st_ff.ed == ED_RUN); // see RULE_08
    if (ed_on) begin // see RULE_06
      nxt_st.sw_on = ~(nxt_st.fault);
    end else if (active && !to_exp) begin
      nxt_st.sw_on = nxt_st.chen & ~nxt_st.fault; // see RULE_11
    end else begin
      nxt_st.sw_on = '0; // see RULE_21
    end

    // per-channel timers stop whenever balancing is interrupted
    nxt_st.hold = st_ff.therm || meas_pause ||
      st_ff.prebal != 16'h0000; // see RULE_02 see RULE_05
  end

  // state register
  // reset branch loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.cfg <= RST_CFG;
      st_ff.timeout <= 16'h0000;
      st_ff.chen <= '0;
      st_ff.prebal <= 16'h0000;
      st_ff.ed_ctrl <= ED_KEY_OFF; // see RULE_22
      st_ff.ed <= ED_OFF; // see RULE_22
      st_ff.mon_en <= {RST_MON_HI, RST_MON_LO};
      st_ff.uv_cell <= '0;
      st_ff.uv_glob <= '0;
      st_ff.fault <= '0;
      st_ff.sw_on <= '0;
      st_ff.therm <= 1'b0;
      st_ff.rdy <= 1'b0;
      st_ff.hold <= 1'b0;
      st_ff.pready <= 1'b0;
      st_ff.pslverr <= 1'b0;
      st_ff.prdata <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign sw_on = st_ff.sw_on;
  assign timers_hold = st_ff.hold;

endmodule

// ### bal_pkg.sv
/*
  constants, register map and state types of the cell balancing sequencer.
  assumes an apb master that addresses one 32-bit word per register index.
*/
package bal_pkg;
  localparam int NCH = 18; // balancing channels
  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_GLOB_CFG = 16'h1000;
  localparam logic [15:0] IDX_TIMEOUT = 16'h1001;
  localparam logic [15:0] IDX_CHEN_LO = 16'h1002;
  localparam logic [15:0] IDX_CHEN_HI = 16'h1003;
  localparam logic [15:0] IDX_PREBAL = 16'h1004;
  localparam logic [15:0] IDX_ED_CTRL = 16'h1005;
  localparam logic [15:0] IDX_MON_LO = 16'h1006;
  localparam logic [15:0] IDX_MON_HI = 16'h1007;
  localparam logic [15:0] IDX_STATUS = 16'h100E;
  localparam logic [15:0] IDX_SW_LO = 16'h1010;
  localparam logic [15:0] IDX_SW_HI = 16'h1011;
  localparam logic [15:0] IDX_FLT_LO = 16'h1012;
  localparam logic [15:0] IDX_FLT_HI = 16'h1013;
  // global config fields
  localparam int CFG_EN = 0;
  localparam int CFG_TMR = 1;
  localparam int CFG_CELLUV = 2;
  localparam int CFG_GLOBUV = 3;
  // status fields
  localparam int ST_RDY = 0;
  localparam int ST_THERM = 1;
  localparam int ST_ED = 2;
  // emergency discharge keys
  localparam logic [15:0] ED_KEY_ON = 16'hDEAD;
  localparam logic [15:0] ED_KEY_OFF = 16'h2152;
  // reset values
  localparam logic [15:0] RST_CFG = 16'h0000;
  localparam logic [15:0] RST_MON_LO = 16'hFFFF;
  localparam logic [1:0] RST_MON_HI = 2'h3;

  typedef enum logic [2:0] {
    ED_OFF = 3'b001,
    ED_RUN = 3'b010,
    ED_HOLD = 3'b100
  } ed_state_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] timeout;
    logic [NCH-1:0] chen;
    logic [15:0] prebal;
    logic [15:0] ed_ctrl;
    ed_state_t ed;
    logic [NCH-1:0] mon_en;
    logic [NCH-1:0] uv_cell;
    logic [NCH-1:0] uv_glob;
    logic [NCH-1:0] fault;
    logic [NCH-1:0] sw_on;
    logic therm;
    logic rdy;
    logic hold;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bal_st_t;
endpackage

// ### cbs_props.sv
/* checker for the balancing sequencer: apb handshake and switch drive.
   assumes it is bound to cell_balancing_sequencer, single clock. */
`timescale 1ns/100ps
module cbs_props
  import bal_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic [15:0] paddr, // byte address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [NCH-1:0] sw_ovc, // switch overcurrent
  input wire logic [NCH-1:0] sw_on // switch drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc; // access cycle still waiting
  logic bad; // a driven switch reports overcurrent
  assign acc = psel && penable && !pready;
  assign bad = |(sw_ovc & sw_on);
  // one wait state, one-cycle answer
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_one_wait: assert property (acc |=> pready) else $error("ready late");
  a_no_stray_ready: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
  // indexes below the block are unmapped
  a_err_unmapped: assert property (acc && paddr[15:2] < 14'h1000 |=> pslverr)
    else $error("unmapped accepted");
  a_cfg_no_err: assert property (acc && paddr == 16'h4000 |=> !pslverr)
    else $error("config refused");
  a_rdata_held: assert property ($changed(prdata) |-> pready) else $error("rdata moved");
  // a faulted switch must not stay driven
  a_fault_opens: assert property (bad |=> !bad) else $error("faulted on");
  cover property (pready && pslverr);
  cover property (&sw_on);
  cover property (bad);
endmodule
bind cell_balancing_sequencer cbs_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sw_ovc(sw_ovc), .sw_on(sw_on));

// ### host_apb_model.sv
/* host controller model: apb master writing and reading balancing registers.
   assumes a slave that answers with pready; the bench watchdog ends hangs. */
`timescale 1ns/100ps
module host_apb_model (
  input wire logic pclk, // clock
  input wire logic pready, // slave ready
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr, // slave error
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [15:0] paddr, // byte address
  output logic [31:0] pwdata // write data
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end
  // setup, access, hold until ready; key words pass unaltered
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, idx, d, q, e);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] q, output logic e);
    xfer(1'b0, idx, 32'h00000000, q, e);
  endtask
endmodule

// ### test_cell_balancing_sequencer.sv
/* self-checking bench for the cell balancing sequencer.
   assumes the host model as apb master and physical switches that follow drive. */
`timescale 1ns/100ps
module test_cell_balancing_sequencer
  import bal_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic tick_10s, meas_pause, meas_done, supply_low, vbat_ov, timers_hold;
  logic [15:0] paddr, jt_temp, jt_upper, jt_hyst;
  logic [31:0] pwdata, prdata, rdv;
  logic [NCH-1:0] cell_uv, glob_uv, tmr_expired, sw_ovc, sw_open_load, sw_on, sw_closed;
  int failures, n_compared;
  assign sw_closed = sw_on; // no lag, so no false deviation faults
  cell_balancing_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tick_10s(tick_10s), .jt_temp(jt_temp),
    .jt_upper(jt_upper), .jt_hyst(jt_hyst), .meas_pause(meas_pause), .meas_done(meas_done),
    .cell_uv(cell_uv), .glob_uv(glob_uv), .tmr_expired(tmr_expired),
    .supply_low(supply_low), .vbat_ov(vbat_ov), .sw_closed(sw_closed), .sw_ovc(sw_ovc),
    .sw_open_load(sw_open_load), .sw_on(sw_on), .timers_hold(timers_hold));
  host_apb_model host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rdchk(input logic [15:0] idx, input logic [31:0] exp);
    host.rd(idx, rdv, err);
    chk(rdv, exp);
  endtask
  task tick; // one 10 s pulse
    tick_10s <= 1'b1;
    @(posedge pclk);
    tick_10s <= 1'b0;
    cyc(2);
  endtask
  task t_reset;
    rdchk(IDX_ED_CTRL, 32'h00002152);
    rdchk(IDX_MON_LO, 32'h0000FFFF);
    host.wr(IDX_STATUS, 32'h00000007); // read-only, ignored
    rdchk(IDX_STATUS, 32'h00000000);
    host.rd(16'h1200, rdv, err);
    chk(32'(err), 32'h00000001);
    host.rd(16'h0100, rdv, err); // index below the map
    chk(32'(err), 32'h00000001);
    $display("t_reset done");
  endtask
  task t_ed;
    host.wr(IDX_TIMEOUT, 32'h00000002);
    host.wr(IDX_ED_CTRL, 32'h0000DEAD); // enable stays 0
    cyc(4);
    chk(32'(sw_on), 32'h0003FFFF);
    tick;
    rdchk(IDX_TIMEOUT, 32'h00000002);
    vbat_ov <= 1'b1;
    cyc(4);
    chk(32'(sw_on), 32'h00000000);
    tick;
    rdchk(IDX_TIMEOUT, 32'h00000001);
    vbat_ov <= 1'b0; // software cleared the flag
    cyc(4);
    chk(32'(sw_on), 32'h0003FFFF);
    host.wr(IDX_ED_CTRL, 32'h00002152);
    cyc(4);
    chk(32'(sw_on), 32'h00000000);
    host.wr(IDX_ED_CTRL, 32'h0000DEAD);
    supply_low <= 1'b1;
    cyc(4);
    chk(32'(sw_on), 32'h00000000);
    rdchk(IDX_ED_CTRL, 32'h00002152);
    supply_low <= 1'b0;
    host.wr(IDX_TIMEOUT, 32'h00000000);
    $display("t_ed done");
  endtask
  task t_bal;
    host.wr(IDX_TIMEOUT, 32'h00000005);
    host.wr(IDX_CHEN_LO, 32'h00000005);
    host.wr(IDX_CHEN_HI, 32'h00000002);
    host.wr(IDX_GLOB_CFG, 32'h00000003);
    cyc(4);
    chk(32'(sw_on), 32'h00020005);
    rdchk(IDX_SW_LO, 32'h00000005);
    rdchk(IDX_SW_HI, 32'h00000002);
    jt_temp <= 16'h0065;
    cyc(4);
    chk(32'(sw_on), 32'h00000000);
    chk(32'(timers_hold), 32'h00000001);
    tick;
    rdchk(IDX_TIMEOUT, 32'h00000004);
    jt_temp <= 16'h005F; // cooled, but not by the full hysteresis
    cyc(4);
    chk(32'(timers_hold), 32'h00000001);
    jt_temp <= 16'h005A;
    cyc(4);
    chk(32'(sw_on), 32'h00020005);
    chk(32'(timers_hold), 32'h00000000);
    meas_pause <= 1'b1;
    cyc(4);
    chk(32'(sw_on), 32'h00000000);
    chk(32'(timers_hold), 32'h00000001);
    tick;
    rdchk(IDX_TIMEOUT, 32'h00000003);
    meas_pause <= 1'b0;
    cyc(4);
    chk(32'(sw_on), 32'h00020005);
    sw_ovc <= 18'h00001; // raised while channel 0 is driven
    cyc(4);
    chk(32'(sw_on), 32'h00020004);
    rdchk(IDX_FLT_LO, 32'h00000001);
    sw_ovc <= 18'h00000;
    host.wr(IDX_FLT_LO, 32'h00000001);
    rdchk(IDX_FLT_LO, 32'h00000000);
    tmr_expired <= 18'h20004;
    cyc(4);
    rdchk(IDX_CHEN_LO, 32'h00000000);
    rdchk(IDX_CHEN_HI, 32'h00000000);
    rdchk(IDX_GLOB_CFG, 32'h00000002);
    rdchk(IDX_STATUS, 32'h00000001);
    tmr_expired <= 18'h00000;
    $display("t_bal done");
  endtask
  task t_glob;
    host.wr(IDX_CHEN_LO, 32'h00000003);
    host.wr(IDX_GLOB_CFG, 32'h00000009);
    glob_uv <= 18'h00002;
    cyc(4);
    rdchk(IDX_CHEN_LO, 32'h00000003); // not latched yet
    meas_done <= 1'b1;
    cyc(1);
    meas_done <= 1'b0;
    cyc(4);
    rdchk(IDX_CHEN_LO, 32'h00000000);
    rdchk(IDX_GLOB_CFG, 32'h00000008);
    glob_uv <= 18'h00000;
    $display("t_glob done");
  endtask
  task t_celluv;
    host.wr(IDX_MON_LO, 32'h0000FFFE); // channel 0 unmonitored
    host.wr(IDX_CHEN_LO, 32'h00000003);
    host.wr(IDX_GLOB_CFG, 32'h00000005);
    sw_open_load <= 18'h00001;
    cell_uv <= 18'h00001;
    cyc(4);
    chk(32'(sw_on), 32'h00000003);
    rdchk(IDX_FLT_LO, 32'h00000000);
    meas_done <= 1'b1;
    cyc(1);
    meas_done <= 1'b0;
    cyc(4);
    rdchk(IDX_CHEN_LO, 32'h00000002);
    cell_uv <= 18'h00003;
    meas_done <= 1'b1;
    cyc(1);
    meas_done <= 1'b0;
    cyc(4);
    rdchk(IDX_CHEN_LO, 32'h00000000);
    rdchk(IDX_GLOB_CFG, 32'h00000004);
    rdchk(IDX_STATUS, 32'h00000001);
    {sw_open_load, cell_uv} <= '0;
    host.wr(IDX_MON_LO, 32'h0000FFFF);
    $display("t_celluv done");
  endtask
  task t_expire;
    host.wr(IDX_TIMEOUT, 32'h00000001);
    host.wr(IDX_CHEN_LO, 32'h00000001);
    host.wr(IDX_GLOB_CFG, 32'h00000001);
    cyc(4);
    chk(32'(sw_on), 32'h00000001);
    tick;
    cyc(2);
    chk(32'(sw_on), 32'h00000000);
    rdchk(IDX_GLOB_CFG, 32'h00000000);
    $display("t_expire done");
  endtask
  task give_verdict;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // watchdog: run needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
  initial begin
    failures = 0;
    n_compared = 0;
    presetn = 1'b0;
    {tick_10s, meas_pause, meas_done, supply_low, vbat_ov} = 5'h00;
    {cell_uv, glob_uv, tmr_expired, sw_ovc, sw_open_load} = '0;
    jt_temp = 16'h0032;
    jt_upper = 16'h0064;
    jt_hyst = 16'h000A;
    cyc(3);
    presetn <= 1'b1;
    t_reset;
    t_ed;
    t_bal;
    t_glob;
    t_celluv;
    t_expire;
    give_verdict;
  end
endmodule
